// *** hw/acsm_top.sv ***
// setup register and operating-mode control of the sigma-delta converter
`timescale 1ns/1ps
// Function
// - eight-bit setup register, reset value 0x01
// - mode 00 runs continuous normal conversions
// - mode 01: self calibration, zero then full
// - mode 10: zero-scale system calibration
// - mode 11: full-scale system calibration
// - finished calibration clears mode to normal
// - flag high from calibration start to word
// - polarity bit: 0 bipolar, 1 unipolar
// - buffer bit: 0 bypassed, 1 in series
// - gain field sets amplifier gain everywhere
// - sync bit holds filter, modulator, calibration
// - first word three update periods after release
// - sync bit spares interface, never raises flag
// - channel comes from communications channel bits
module acsm_top #(
  parameter int SETTLE = acsm_pkg::SETTLE_WORDS
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  // register access from the serial interface, already decoded
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [2:0] acc_reg_sel,
  input wire logic [7:0] acc_wdata,
  output logic [7:0] acc_rdata,
  // channel bits held in the communications register
  input wire logic channel_sel_hi,
  input wire logic channel_sel_lo,
  // one pulse per filter output-update period
  input wire logic word_tick,
  // converter controls
  output logic [1:0] op_mode,
  output logic [2:0] gain_sel,
  output logic unipolar_sel,
  output logic buffer_en,
  output logic filter_sync_hold,
  output logic [1:0] conv_channel,
  output logic cal_internal,
  output logic zero_scale,
  output logic full_scale,
  output logic data_load,
  output logic conversion_ready_flag
);
  // the sequencer counter is four bits wide, so longer settling cannot be served
  if (SETTLE < 1 || SETTLE > 15)
  begin : g_settle_check
    $error("acsm_top: SETTLE must be 1..15");
  end

  logic [7:0] setup; // setup register contents
  logic [1:0] write_mode; // mode field carried by the present write
  logic setup_wr; // host writes the setup register
  logic setup_rd; // host reads the setup register
  logic data_rd; // host reads the data register
  logic cal_start; // write that starts a calibration

  acsm_ctrl_if ctrl ();

  // mode field of a setup value; write path, register and outputs all need it
  function automatic logic [1:0] mode_of(input logic [7:0] v);
    mode_of = v[acsm_pkg::MODE_HI_POS:acsm_pkg::MODE_LO_POS];
  endfunction : mode_of

  // gain field of a setup value
  function automatic logic [2:0] gain_of(input logic [7:0] v);
    gain_of = v[acsm_pkg::GAIN_HI_POS:acsm_pkg::GAIN_LO_POS];
  endfunction : gain_of

  // access decode; the host has already pointed the port at one register
  // other codes fall through untouched, and a data register write is dropped
  // here because that register is read only for the host
  assign setup_wr = acc_valid && acc_write && (acc_reg_sel == acsm_pkg::SEL_SETUP);
  assign setup_rd = acc_valid && !acc_write && (acc_reg_sel == acsm_pkg::SEL_SETUP);
  assign data_rd = acc_valid && !acc_write && (acc_reg_sel == acsm_pkg::SEL_DATA);
  assign write_mode = mode_of(acc_wdata);
  // sync hold set in the same write keeps calibration waiting, not lost
  assign cal_start = setup_wr && acsm_pkg::is_cal(write_mode);

  // setup register; a host write wins over the automatic mode clear
  // so a write landing on the last calibration tick keeps the host's mode
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      setup <= acsm_pkg::SETUP_RESET;
    else if (setup_wr)
      setup <= acc_wdata;
    else if (ctrl.cal_done)
      setup[acsm_pkg::MODE_HI_POS:acsm_pkg::MODE_LO_POS] <= acsm_pkg::MODE_NORMAL;
  end

  // register fields toward the sequencer
  // mode and sync go straight from the register, not via the output copies
  assign ctrl.mode = mode_of(setup);
  assign ctrl.hold = setup[acsm_pkg::SYNC_POS];
  // every setup write restarts the sequencer, whatever mode it carries
  assign ctrl.start = setup_wr;

  // read data; other registers live elsewhere and read zero here
  // the conversion word itself is served by the output path, not by this block
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      acc_rdata <= 8'h00;
    else if (setup_rd)
      acc_rdata <= setup;
    else
      acc_rdata <= 8'h00;
  end

  // mode copy for the converter; one cycle behind the register, like every field
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      op_mode <= mode_of(acsm_pkg::SETUP_RESET);
    else
      op_mode <= mode_of(setup);
  end

  // amplifier gain, used alike for conversions and calibrations
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      gain_sel <= gain_of(acsm_pkg::SETUP_RESET);
    else
      gain_sel <= gain_of(setup);
  end

  // input polarity: 0 bipolar, 1 unipolar
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      unipolar_sel <= acsm_pkg::SETUP_RESET[acsm_pkg::POLARITY_POS];
    else
      unipolar_sel <= setup[acsm_pkg::POLARITY_POS];
  end

  // input buffer: 0 bypassed to save supply current, 1 in series
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      buffer_en <= acsm_pkg::SETUP_RESET[acsm_pkg::BUFFER_POS];
    else
      buffer_en <= setup[acsm_pkg::BUFFER_POS];
  end

  // sync hold toward filter and modulator; the host port is never held by it
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      filter_sync_hold <= acsm_pkg::SETUP_RESET[acsm_pkg::SYNC_POS];
    else
      filter_sync_hold <= setup[acsm_pkg::SYNC_POS];
  end

  // channel taken from the communications register bits
  // limitation: not latched per calibration, the host keeps the bits steady
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      conv_channel <= 2'h0;
    else
      conv_channel <= {channel_sel_hi, channel_sel_lo};
  end

  // calibration step indicators, one cycle behind the sequencer
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      zero_scale <= 1'b0;
      full_scale <= 1'b0;
      cal_internal <= 1'b0;
    end
    else
    begin
      zero_scale <= ctrl.step_zs;
      full_scale <= ctrl.step_fs;
      // internal shorted inputs and reference only in self calibration
      cal_internal <= (ctrl.step_zs || ctrl.step_fs) &&
        (ctrl.mode == acsm_pkg::MODE_SELF_CAL);
    end
  end

  // load strobe toward the data register; the flag below falls on the same edge
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      data_load <= 1'b0;
    else
      data_load <= ctrl.word_load;
  end

  // ready flag: high means no unread valid word
  // setting wins over clearing, so a start never gets lost
  // a data register read marks the word as taken, the next load clears it
  // limitation: a read racing a load leaves the flag high until the next word
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      conversion_ready_flag <= acsm_pkg::FLAG_RESET;
    else if (cal_start || data_rd)
      conversion_ready_flag <= 1'b1;
    else if (ctrl.word_load)
      conversion_ready_flag <= 1'b0;
    // a write that only sets sync hold leaves the flag alone
  end

  // sequencer; it keeps running while the host talks
  // a setup write in mid-calibration aborts it and starts over per the new mode
  acsm_seq #(
    .SETTLE(SETTLE)
  ) u_seq (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .word_tick(word_tick),
    .ctrl(ctrl.seq)
  );
endmodule : acsm_top

// *** hw/acsm_pkg.sv ***
// package: constants and types for the converter setup and mode control
package acsm_pkg;
  // register select codes seen on the register access port
  localparam logic [2:0] SEL_SETUP = 3'h1;
  localparam logic [2:0] SEL_DATA = 3'h3;
  // setup register field positions
  localparam int MODE_HI_POS = 7;
  localparam int MODE_LO_POS = 6;
  localparam int GAIN_HI_POS = 5;
  localparam int GAIN_LO_POS = 3;
  localparam int POLARITY_POS = 2;
  localparam int BUFFER_POS = 1;
  localparam int SYNC_POS = 0;
  // setup register reset value: only the sync hold bit set
  localparam logic [7:0] SETUP_RESET = 8'h01;
  // operating mode codes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_SELF_CAL = 2'h1;
  localparam logic [1:0] MODE_ZS_CAL = 2'h2;
  localparam logic [1:0] MODE_FS_CAL = 2'h3;
  // filter settling time in output-update periods
  localparam int SETTLE_WORDS = 3;
  // flag value after reset: high means no valid word yet
  localparam logic FLAG_RESET = 1'b1;

  // sequencer states
  typedef enum logic [2:0] {
    ST_HOLD,
    ST_SETTLE,
    ST_CONVERT,
    ST_CAL_ZS,
    ST_CAL_FS
  } acsm_state_type;

  // any non-normal mode code requests a calibration
  function automatic logic is_cal(input logic [1:0] mode);
    is_cal = (mode != MODE_NORMAL);
  endfunction : is_cal
endpackage : acsm_pkg

// *** hw/acsm_ctrl_if.sv ***
// interface: control between the setup register and the conversion sequencer
`timescale 1ns/1ps
interface acsm_ctrl_if;
  logic [1:0] mode; // current operating mode field
  logic hold; // sync hold bit
  logic start; // pulse: setup written, restart per mode
  logic cal_done; // pulse: last calibration step finished
  logic word_load; // pulse: valid word goes to data register
  logic step_zs; // zero-scale step running
  logic step_fs; // full-scale step running

  modport regs (output mode, output hold, output start,
                input cal_done, input word_load, input step_zs, input step_fs);
  modport seq (input mode, input hold, input start,
               output cal_done, output word_load, output step_zs, output step_fs);
endinterface : acsm_ctrl_if

// *** hw/acsm_seq.sv ***
// conversion and calibration sequencer driven by output-update ticks
`timescale 1ns/1ps
module acsm_seq #(
  parameter int SETTLE = acsm_pkg::SETTLE_WORDS
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic word_tick,
  acsm_ctrl_if.seq ctrl
);
  // counter is four bits wide, so a longer settling time cannot be counted
  if (SETTLE < 1 || SETTLE > 15)
  begin : g_settle_check
    $error("acsm_seq: SETTLE must be 1..15");
  end

  acsm_pkg::acsm_state_type state; // sequencer state
  acsm_pkg::acsm_state_type next_state; // state after this cycle
  logic [3:0] tick_count; // update periods seen in this step
  logic step_end; // this tick ends the current step

  assign step_end = word_tick && (tick_count == 4'(SETTLE - 1));

  // next state choice
  always_comb
  begin
    next_state = state;
    case (state)
      acsm_pkg::ST_HOLD:
        if (!ctrl.hold)
          next_state = acsm_pkg::is_cal(ctrl.mode) ?
            ((ctrl.mode == acsm_pkg::MODE_FS_CAL) ? acsm_pkg::ST_CAL_FS : acsm_pkg::ST_CAL_ZS)
            : acsm_pkg::ST_SETTLE;
      acsm_pkg::ST_SETTLE:
        if (step_end)
          next_state = acsm_pkg::ST_CONVERT;
      acsm_pkg::ST_CONVERT:
        next_state = acsm_pkg::ST_CONVERT;
      acsm_pkg::ST_CAL_ZS:
        if (step_end)
          next_state = (ctrl.mode == acsm_pkg::MODE_SELF_CAL) ?
            acsm_pkg::ST_CAL_FS : acsm_pkg::ST_SETTLE;
      acsm_pkg::ST_CAL_FS:
        if (step_end)
          next_state = acsm_pkg::ST_SETTLE;
      default:
        next_state = acsm_pkg::ST_HOLD;
    endcase
    // a setup write restarts the sequence per the new mode
    if (ctrl.start)
      next_state = acsm_pkg::ST_HOLD;
    // sync hold keeps filter and calibration control in reset
    if (ctrl.hold)
      next_state = acsm_pkg::ST_HOLD;
  end

  // state register
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      state <= acsm_pkg::ST_HOLD;
    else
      state <= next_state;
  end

  // tick counter restarts with every step
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || next_state != state || state == acsm_pkg::ST_HOLD)
      tick_count <= 4'h0;
    else if (word_tick && state != acsm_pkg::ST_CONVERT)
      tick_count <= tick_count + 4'h1;
  end

  // event pulses toward the register side
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      ctrl.cal_done <= 1'b0;
      ctrl.word_load <= 1'b0;
    end
    else
    begin
      ctrl.cal_done <= !ctrl.start && !ctrl.hold && step_end &&
        ((state == acsm_pkg::ST_CAL_FS) ||
         (state == acsm_pkg::ST_CAL_ZS && ctrl.mode == acsm_pkg::MODE_ZS_CAL));
      ctrl.word_load <= !ctrl.start && !ctrl.hold &&
        ((state == acsm_pkg::ST_SETTLE && step_end) ||
         (state == acsm_pkg::ST_CONVERT && word_tick));
    end
  end

  assign ctrl.step_zs = (state == acsm_pkg::ST_CAL_ZS);
  assign ctrl.step_fs = (state == acsm_pkg::ST_CAL_FS);
endmodule : acsm_seq

// *** verif/acsm_host.sv ***
// host controller model: one register access per call
`timescale 1ns/1ps
module acsm_host (
  input wire logic sys_clk,
  input wire logic [7:0] acc_rdata,
  output logic acc_valid,
  output logic acc_write,
  output logic [2:0] acc_reg_sel,
  output logic [7:0] acc_wdata
);
  // idle port at time zero
  initial
  begin
    {acc_valid, acc_write, acc_reg_sel, acc_wdata} = 12'h000;
  end
  // register select, then exactly one access
  task automatic access(input logic w, input logic [2:0] sel, input logic [7:0] d,
                        output logic [7:0] q);
    @(negedge sys_clk);
    {acc_valid, acc_write, acc_reg_sel, acc_wdata} = {1'b1, w, sel, d};
    @(negedge sys_clk);
    q = acc_rdata;
    // released lines show no stale value
    {acc_valid, acc_write, acc_reg_sel, acc_wdata} = {1'b0, ~w, ~sel, ~d};
  endtask : access
endmodule : acsm_host

// *** verif/acsm_top_properties.sv ***
// checker of the setup register and sequencer ports
`timescale 1ns/1ps
module acsm_top_properties #(parameter int SETTLE = 3) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [2:0] acc_reg_sel,
  input wire logic [7:0] acc_wdata,
  input wire logic [7:0] acc_rdata,
  input wire logic channel_sel_hi,
  input wire logic channel_sel_lo,
  input wire logic [1:0] op_mode,
  input wire logic [2:0] gain_sel,
  input wire logic unipolar_sel,
  input wire logic buffer_en,
  input wire logic filter_sync_hold,
  input wire logic [1:0] conv_channel,
  input wire logic cal_internal,
  input wire logic zero_scale,
  input wire logic full_scale,
  input wire logic data_load,
  input wire logic conversion_ready_flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  AST_SETUP_WRITE: assert property (acc_valid && acc_write && acc_reg_sel == 3'h1 |-> ##2
    {op_mode, gain_sel, unipolar_sel, buffer_en, filter_sync_hold} == $past(acc_wdata, 2))
    else $error("setup fields differ from write");
  AST_RDATA_IDLE: assert property (!(acc_valid && !acc_write && acc_reg_sel == 3'h1)
    |=> acc_rdata == 8'h00) else $error("read data not idle");
  AST_CHANNEL: assert property (1'b1 |=> conv_channel == $past({channel_sel_hi, channel_sel_lo}))
    else $error("channel not followed");
  AST_HOLD_NO_LOAD: assert property (filter_sync_hold && $past(filter_sync_hold, 3)
    |-> !data_load) else $error("word loaded under hold");
  AST_CAL_FLAG: assert property (zero_scale || full_scale |-> conversion_ready_flag && !data_load)
    else $error("flag low during calibration");
  AST_SELF_STEP: assert property ($rose(cal_internal) |-> op_mode == 2'h1 && zero_scale)
    else $error("self calibration step wrong");
  AST_ZS_STEP: assert property ($rose(zero_scale) |-> op_mode inside {2'h1, 2'h2})
    else $error("zero step in wrong mode");
  AST_FS_STEP: assert property ($rose(full_scale) |-> op_mode inside {2'h1, 2'h3})
    else $error("full step in wrong mode");
  AST_MODE_RETURN: assert property ($fell(full_scale) && op_mode == 2'h3 |-> ##[0:4]
    op_mode == 2'h0) else $error("mode not cleared");
  AST_LOAD_FLAG: assert property (data_load && !$past(acc_valid) && !$past(acc_valid, 2)
    |-> !conversion_ready_flag) else $error("flag high with new word");
endmodule : acsm_top_properties

// *** verif/test_acsm_top.sv ***
// self-checking bench for the converter setup and mode control
`timescale 1ns/1ps
module test_acsm_top;
  logic sys_clk = 1'b0; // 100 MHz
  logic sys_rst = 1'b1;
  logic word_tick = 1'b0; // update period pulse
  logic channel_sel_hi = 1'b0;
  logic channel_sel_lo = 1'b0;
  logic acc_valid, acc_write, unipolar_sel, buffer_en, filter_sync_hold;
  logic cal_internal, zero_scale, full_scale, data_load, conversion_ready_flag;
  logic [1:0] op_mode, conv_channel;
  logic [2:0] acc_reg_sel, gain_sel, seen;
  logic [7:0] acc_wdata, acc_rdata, q, d, l0;
  logic [7:0] loads = 8'h00; // data_load pulses seen
  logic seen_clr = 1'b1; // clears the step record while high
  int mismatches = 0;
  int comparisons = 0;
  wire logic [7:0] setup_out = {op_mode, gain_sel, unipolar_sel, buffer_en, filter_sync_hold};
  acsm_top dut (.*);
  acsm_host host (.*);
  initial forever #5 sys_clk = ~sys_clk;
  // count loads and calibration steps seen
  always @(posedge sys_clk)
  begin
    if (data_load === 1'b1) loads <= loads + 8'h01;
    if (seen_clr)
      seen <= 3'h0;
    else
      seen <= seen | {cal_internal, zero_scale, full_scale};
  end
  // calibration leaves mode at normal
  function automatic logic [7:0] after_cal(input logic [7:0] v);
    after_cal = {2'h0, v[5:0]};
  endfunction : after_cal
  // steps expected: internal, zero, full
  function automatic logic [2:0] steps(input logic [1:0] m);
    steps = (m == 2'h1) ? 3'h7 : {1'b0, m == 2'h2, m == 2'h3};
  endfunction : steps
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task conclude();
    if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  // update ticks with random spacing, long enough for the load
  task ticks(input int n);
    repeat (n)
    begin
      @(negedge sys_clk) word_tick = 1'b1;
      @(negedge sys_clk) word_tick = 1'b0;
      repeat ($urandom_range(8, 4)) @(negedge sys_clk);
    end
  endtask : ticks
  // setup write, then wait for the registered copies
  task wr(input logic [7:0] v);
    host.access(1'b1, 3'h1, v, q);
    @(negedge sys_clk);
  endtask : wr
  // watchdog: the scenarios need a few hundred cycles, ten thousand are allowed
  initial
  begin
    #100000;
    mismatches++;
    conclude();
  end
  initial
  begin
    void'($urandom(32'h1e51_1c04));
    repeat (8) @(negedge sys_clk);
    sys_rst = 1'b0;
    host.access(1'b0, 3'h1, 8'h00, q);
    chk8(q, 8'h01);
    chk8(setup_out, 8'h01);
    wr(8'h00);
    l0 = loads;
    ticks(2);
    chk8(loads - l0, 8'h00);
    ticks(1);
    chk8(loads - l0, 8'h01);
    ticks(4);
    chk8(loads - l0, 8'h05);
    chk8({7'h00, conversion_ready_flag}, 8'h00);
    // a data register read marks the word as taken; the next word clears the flag
    host.access(1'b0, 3'h3, 8'h00, q);
    chk8(q, 8'h00);
    chk8({7'h00, conversion_ready_flag}, 8'h01);
    ticks(1);
    chk8({7'h00, conversion_ready_flag}, 8'h00);
    wr(8'h01);
    l0 = loads;
    ticks(3);
    chk8({7'h00, conversion_ready_flag}, 8'h00);
    chk8(loads - l0, 8'h00);
    host.access(1'b1, 3'h5, 8'hff, q);
    host.access(1'b0, 3'h1, 8'h00, q);
    chk8(q, 8'h01);
    repeat (6)
    begin
      {channel_sel_hi, channel_sel_lo} = 2'($urandom);
      d = 8'($urandom) & 8'h3f;
      wr(d);
      chk8(setup_out, d);
      chk8({6'h00, conv_channel}, {6'h00, channel_sel_hi, channel_sel_lo});
      host.access(1'b0, 3'h1, 8'h00, q);
      chk8(q, d);
    end
    for (int m = 1; m < 4; m++)
    begin
      d = {2'(m), 5'($urandom), 1'b0};
      seen_clr = 1'b1;
      wr(d);
      seen_clr = 1'b0;
      chk8(setup_out, d);
      chk8({7'h00, conversion_ready_flag}, 8'h01);
      for (int k = 0; k < 24 && op_mode !== 2'h0; k++) ticks(1);
      chk8(setup_out, after_cal(d));
      chk8({5'h00, seen}, {5'h00, steps(2'(m))});
      ticks(3);
      chk8({7'h00, conversion_ready_flag}, 8'h00);
    end
    conclude();
  end
endmodule : test_acsm_top
bind acsm_top acsm_top_properties #(.SETTLE(SETTLE)) props (.*);
